// ---- bridge_port_option_pkg.sv ----
// constants and types shared by the port option control block
package bridge_port_option_pkg;

  // register map, byte addresses
  localparam logic [7:0]  OPT_REG_ADDR    = 8'h74;
  localparam logic [7:0]  STATUS_REG_ADDR = 8'h78;

  // option field positions
  localparam int unsigned P_READ_ALIAS_BIT  = 1;
  localparam int unsigned P_WRITE_ALIAS_BIT = 2;
  localparam int unsigned S_READ_ALIAS_BIT  = 3;
  localparam int unsigned S_WRITE_ALIAS_BIT = 4;
  localparam int unsigned P_LM_ALIAS_BIT    = 5;
  localparam int unsigned S_LM_ALIAS_BIT    = 6;
  localparam int unsigned P_MWI_KEEP_BIT    = 7;
  localparam int unsigned S_MWI_KEEP_BIT    = 8;
  localparam int unsigned LONG_REQ_BIT      = 9;
  localparam int unsigned S_HOLD_REQ_BIT    = 10;
  localparam int unsigned P_HOLD_REQ_BIT    = 11;

  // reset value and writable bits of the option register
  localparam logic [15:0] OPT_RESET_VALUE = 16'h0c6a;
  localparam logic [15:0] OPT_WRITE_MASK  = 16'h0ffe;

  // status register field positions
  localparam int unsigned STAT_P_REQ_BIT  = 0;
  localparam int unsigned STAT_S_REQ_BIT  = 1;
  localparam int unsigned STAT_P_HOLD_BIT = 2;
  localparam int unsigned STAT_S_HOLD_BIT = 3;

  // bus command codes
  localparam logic [3:0] PLAIN_READ_CMD    = 4'h6;
  localparam logic [3:0] PLAIN_WRITE_CMD   = 4'h7;
  localparam logic [3:0] READ_MULTIPLE_CMD = 4'hc;
  localparam logic [3:0] READ_LINE_CMD     = 4'he;
  localparam logic [3:0] WRITE_INVALIDATE_CMD = 4'hf;

  typedef enum logic [1:0] {
    REQ_IDLE,
    REQ_ASK,
    REQ_HOLD,
    REQ_RELEASE
  } req_state_t;

endpackage

// ---- port_request_ctrl.sv ----
// request line control of one internal bus master
`timescale 1ns/1ps
`default_nettype none

module port_request_ctrl
  import bridge_port_option_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic srst,
  input  wire logic hold_en,
  input  wire logic long_req_en,
  input  wire logic queue_pending,
  input  wire logic frame_start,
  input  wire logic target_term,
  input  wire logic lock_cycle,
  input  wire logic xfer_done,
  output logic      req_n,
  output logic      holding
);

  typedef struct packed {
    req_state_t state;
    logic       hold;
    logic       lock_hold;
    logic       req_n;
  } req_ctrl_t;

  req_ctrl_t state_reg;
  req_ctrl_t state_next;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_next = state_reg;
    case (state_reg.state)
      REQ_IDLE: begin
        if (queue_pending) begin
          state_next.state     = REQ_ASK;
          state_next.req_n     = 1'b0;
          // options sampled once per request, later writes wait
          state_next.hold      = hold_en;
          state_next.lock_hold = long_req_en & lock_cycle;
        end
      end
      REQ_ASK: begin
        if (frame_start) begin
          if (state_reg.hold || state_reg.lock_hold) begin
            state_next.state = REQ_HOLD;
          end else begin
            state_next.state = REQ_RELEASE;
            state_next.req_n = 1'b1;
          end
        end else if (!queue_pending) begin
          state_next.state = REQ_IDLE;
          state_next.req_n = 1'b1;
        end
      end
      REQ_HOLD: begin
        // lock with long request keeps the line until the lock ends or the target terminates
        if (target_term || (!queue_pending && !(state_reg.lock_hold && lock_cycle))) begin
          state_next.state = REQ_IDLE;
          state_next.req_n = 1'b1;
        end
      end
      REQ_RELEASE: begin
        if (xfer_done) begin
          state_next.state = REQ_IDLE;
        end
      end
      default: begin
        state_next.state = REQ_IDLE;
        state_next.req_n = 1'b1;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_reg <= '{state: REQ_IDLE, hold: 1'b0, lock_hold: 1'b0, req_n: 1'b1};
    end else begin
      state_reg <= state_next;
    end
  end

  assign req_n   = state_reg.req_n;
  assign holding = (state_reg.state == REQ_HOLD);

endmodule

`default_nettype wire

// ---- bridge_port_option_control.sv ----
// port option register with retry matching, command conversion and request control
//
// Functional notes
// - primary read retries match exactly at 0, read line or multiple match a plain read at 1, reset 1.
// - secondary read retries follow the same read alias scheme with their own bit, reset 1.
// - primary non-posted write retries accept write-invalidate for a plain write when set, reset 0.
// - secondary non-posted write retries accept write-invalidate for a plain write when set, reset 0.
// - primary read line and read multiple retries match each other when set, reset 1.
// - secondary read line and read multiple retries match each other when set, reset 1.
// - primary write-invalidate is forwarded as plain write at 0 and kept at 1, reset 0.
// - secondary write-invalidate is forwarded as plain write at 0 and kept at 1, reset 0.
// - long request enable keeps the request line up through lock cycles until a target termination, reset 0.
// - secondary master drops its request after frame at 0, holds it while work is pending until a target termination at 1, reset 1.
// - primary master drops its request after frame at 0, holds it while work is pending until a target termination at 1, reset 1.
// - bits 0 and 15 to 12 read zero, reset zero and ignore writes.
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module bridge_port_option_control
  import bridge_port_option_pkg::*;
#(
  parameter int unsigned NUM_PORTS = 2
)
(
  input  wire logic        core_clk,
  input  wire logic        srst,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [31:0] reg_rdata,
  // primary retry matching
  input  wire logic        p_retry_valid,
  input  wire logic [3:0]  p_retry_cmd,
  input  wire logic [3:0]  p_pend_cmd,
  output logic             p_match_valid,
  output logic             p_match_hit,
  // secondary retry matching
  input  wire logic        s_retry_valid,
  input  wire logic [3:0]  s_retry_cmd,
  input  wire logic [3:0]  s_pend_cmd,
  output logic             s_match_valid,
  output logic             s_match_hit,
  // commands accepted on primary, bound for the secondary bus
  input  wire logic        p_fwd_valid,
  input  wire logic [3:0]  p_fwd_cmd,
  output logic             p_out_valid,
  output logic      [3:0]  p_out_cmd,
  // commands accepted on secondary, bound for the primary bus
  input  wire logic        s_fwd_valid,
  input  wire logic [3:0]  s_fwd_cmd,
  output logic             s_out_valid,
  output logic      [3:0]  s_out_cmd,
  // primary internal master
  input  wire logic        p_queue_pending,
  input  wire logic        p_frame_start,
  input  wire logic        p_target_term,
  input  wire logic        p_lock_cycle,
  input  wire logic        p_xfer_done,
  output logic             p_req_n,
  // secondary internal master
  input  wire logic        s_queue_pending,
  input  wire logic        s_frame_start,
  input  wire logic        s_target_term,
  input  wire logic        s_lock_cycle,
  input  wire logic        s_xfer_done,
  output logic             s_req_n
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic [15:0]                opt;
    logic [31:0]                rdata;
    logic [NUM_PORTS-1:0]       match_valid;
    logic [NUM_PORTS-1:0]       match_hit;
    logic [NUM_PORTS-1:0]       out_valid;
    logic [NUM_PORTS-1:0][3:0]  out_cmd;
  } opt_state_t;

  opt_state_t state_reg;
  opt_state_t state_next;

  // per port views, index 0 primary, 1 secondary
  logic [NUM_PORTS-1:0]      retry_valid;
  logic [NUM_PORTS-1:0][3:0] retry_cmd;
  logic [NUM_PORTS-1:0][3:0] pend_cmd;
  logic [NUM_PORTS-1:0]      fwd_valid;
  logic [NUM_PORTS-1:0][3:0] fwd_cmd;
  logic [NUM_PORTS-1:0]      read_alias;
  logic [NUM_PORTS-1:0]      write_alias;
  logic [NUM_PORTS-1:0]      lm_alias;
  logic [NUM_PORTS-1:0]      mwi_keep;
  logic [NUM_PORTS-1:0]      hold_en;
  logic [NUM_PORTS-1:0]      queue_pending;
  logic [NUM_PORTS-1:0]      frame_start;
  logic [NUM_PORTS-1:0]      target_term;
  logic [NUM_PORTS-1:0]      lock_cycle;
  logic [NUM_PORTS-1:0]      xfer_done;
  logic [NUM_PORTS-1:0]      req_n;
  logic [NUM_PORTS-1:0]      holding;
  logic [15:0]               status;

  ////////////////////////////////////////////////////////////////////////////
  // option fields per port

  assign read_alias[0]  = state_reg.opt[P_READ_ALIAS_BIT];
  assign read_alias[1]  = state_reg.opt[S_READ_ALIAS_BIT];
  assign write_alias[0] = state_reg.opt[P_WRITE_ALIAS_BIT];
  assign write_alias[1] = state_reg.opt[S_WRITE_ALIAS_BIT];
  assign lm_alias[0]    = state_reg.opt[P_LM_ALIAS_BIT];
  assign lm_alias[1]    = state_reg.opt[S_LM_ALIAS_BIT];
  assign mwi_keep[0]    = state_reg.opt[P_MWI_KEEP_BIT];
  assign mwi_keep[1]    = state_reg.opt[S_MWI_KEEP_BIT];
  assign hold_en[0]     = state_reg.opt[P_HOLD_REQ_BIT];
  assign hold_en[1]     = state_reg.opt[S_HOLD_REQ_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // gather port signals

  assign retry_valid   = {s_retry_valid, p_retry_valid};
  assign retry_cmd     = {s_retry_cmd, p_retry_cmd};
  assign pend_cmd      = {s_pend_cmd, p_pend_cmd};
  assign fwd_valid     = {s_fwd_valid, p_fwd_valid};
  assign fwd_cmd       = {s_fwd_cmd, p_fwd_cmd};
  assign queue_pending = {s_queue_pending, p_queue_pending};
  assign frame_start   = {s_frame_start, p_frame_start};
  assign target_term   = {s_target_term, p_target_term};
  assign lock_cycle    = {s_lock_cycle, p_lock_cycle};
  assign xfer_done     = {s_xfer_done, p_xfer_done};

  ////////////////////////////////////////////////////////////////////////////
  // command helpers

  function automatic logic cmd_match(
    input logic [3:0] retry,
    input logic [3:0] pend,
    input logic       rd_al,
    input logic       wr_al,
    input logic       lm_al
  );
    logic hit;
    logic is_line_mult;
    is_line_mult = (retry == READ_LINE_CMD) || (retry == READ_MULTIPLE_CMD);
    hit = (retry == pend);
    // line or multiple retry against a pending plain read
    if (rd_al && is_line_mult && (pend == PLAIN_READ_CMD)) begin
      hit = 1'b1;
    end
    // line and multiple interchangeable
    if (lm_al && is_line_mult && ((pend == READ_LINE_CMD) || (pend == READ_MULTIPLE_CMD))) begin
      hit = 1'b1;
    end
    // write-invalidate retry against a pending plain write
    if (wr_al && (retry == WRITE_INVALIDATE_CMD) && (pend == PLAIN_WRITE_CMD)) begin
      hit = 1'b1;
    end
    return hit;
  endfunction

  function automatic logic [3:0] cmd_convert(
    input logic [3:0] cmd,
    input logic       keep
  );
    logic [3:0] res;
    res = cmd;
    if (!keep && (cmd == WRITE_INVALIDATE_CMD)) begin
      res = PLAIN_WRITE_CMD;
    end
    return res;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    state_next = state_reg;
    state_next.rdata = 32'h0000_0000;

    // register writes, reserved bits forced to zero
    if (reg_write && (reg_addr == OPT_REG_ADDR)) begin
      state_next.opt = reg_wdata[15:0] & OPT_WRITE_MASK;
    end

    // read data stand for one cycle only
    if (reg_read) begin
      case (reg_addr)
        OPT_REG_ADDR: begin
          state_next.rdata = {16'h0000, state_reg.opt & OPT_WRITE_MASK};
        end
        STATUS_REG_ADDR: begin
          state_next.rdata = {16'h0000, status};
        end
        default: begin
          state_next.rdata = 32'h0000_0000;
        end
      endcase
    end

    // matching and conversion use options as they stand now, so a
    // write in this cycle only affects requests from the next one
    for (int i = 0; i < NUM_PORTS; i++) begin
      state_next.match_valid[i] = retry_valid[i];
      state_next.match_hit[i]   = 1'b0;
      if (retry_valid[i]) begin
        state_next.match_hit[i] = cmd_match(retry_cmd[i], pend_cmd[i], read_alias[i],
                                            write_alias[i], lm_alias[i]);
      end
      state_next.out_valid[i] = fwd_valid[i];
      if (fwd_valid[i]) begin
        state_next.out_cmd[i] = cmd_convert(fwd_cmd[i], mwi_keep[i]);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_reg.opt         <= OPT_RESET_VALUE;
      state_reg.rdata       <= 32'h0000_0000;
      state_reg.match_valid <= '0;
      state_reg.match_hit   <= '0;
      state_reg.out_valid   <= '0;
      state_reg.out_cmd     <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // request control per internal master

  for (genvar g = 0; g < NUM_PORTS; g++) begin : gen_req
    port_request_ctrl u_req (
      .core_clk      (core_clk),
      .srst          (srst),
      .hold_en       (hold_en[g]),
      .long_req_en   (state_reg.opt[LONG_REQ_BIT]),
      .queue_pending (queue_pending[g]),
      .frame_start   (frame_start[g]),
      .target_term   (target_term[g]),
      .lock_cycle    (lock_cycle[g]),
      .xfer_done     (xfer_done[g]),
      .req_n         (req_n[g]),
      .holding       (holding[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // status view of the masters

  always_comb begin
    status = 16'h0000;
    status[STAT_P_REQ_BIT]  = ~req_n[0];
    status[STAT_S_REQ_BIT]  = ~req_n[1];
    status[STAT_P_HOLD_BIT] = holding[0];
    status[STAT_S_HOLD_BIT] = holding[1];
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign reg_rdata     = state_reg.rdata;
  assign p_match_valid = state_reg.match_valid[0];
  assign p_match_hit   = state_reg.match_hit[0];
  assign s_match_valid = state_reg.match_valid[1];
  assign s_match_hit   = state_reg.match_hit[1];
  assign p_out_valid   = state_reg.out_valid[0];
  assign p_out_cmd     = state_reg.out_cmd[0];
  assign s_out_valid   = state_reg.out_valid[1];
  assign s_out_cmd     = state_reg.out_cmd[1];
  assign p_req_n       = req_n[0];
  assign s_req_n       = req_n[1];

endmodule

`default_nettype wire

// ---- bridge_port_option_monitor.sv ----
// assertion checker for the port option control block
`timescale 1ns/1ps
`default_nettype none
module bridge_port_option_monitor
  import bridge_port_option_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        srst,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_write,
  input wire logic        reg_read,
  input wire logic [31:0] reg_rdata,
  input wire logic        p_retry_valid,
  input wire logic [3:0]  p_retry_cmd,
  input wire logic [3:0]  p_pend_cmd,
  input wire logic        p_match_valid,
  input wire logic        p_match_hit,
  input wire logic        s_retry_valid,
  input wire logic [3:0]  s_retry_cmd,
  input wire logic [3:0]  s_pend_cmd,
  input wire logic        s_match_valid,
  input wire logic        s_match_hit,
  input wire logic        p_fwd_valid,
  input wire logic [3:0]  p_fwd_cmd,
  input wire logic        p_out_valid,
  input wire logic [3:0]  p_out_cmd,
  input wire logic        s_fwd_valid,
  input wire logic [3:0]  s_fwd_cmd,
  input wire logic        s_out_valid,
  input wire logic [3:0]  s_out_cmd,
  input wire logic        p_queue_pending,
  input wire logic        p_frame_start,
  input wire logic        p_target_term,
  input wire logic        p_lock_cycle,
  input wire logic        p_req_n,
  input wire logic        s_queue_pending,
  input wire logic        s_frame_start,
  input wire logic        s_target_term,
  input wire logic        s_lock_cycle,
  input wire logic        s_req_n
);
  logic [15:0] opt;
  logic [15:0] opt_d;
  logic        lk_d;
  logic        ph;
  logic        sh;
  logic        pl;
  logic        sl;
  logic        slk_d;
  logic        pg;
  logic [3:0]  p_fx;
  logic [3:0]  s_fx;
  ////////////////////////////////////////////////////////////////////////////////
  // shadow of the option register and the hold choice taken at request start
  always_ff @(posedge core_clk) begin
    opt   <= srst ? OPT_RESET_VALUE : (reg_write && reg_addr == OPT_REG_ADDR) ? reg_wdata[15:0] & OPT_WRITE_MASK : opt;
    opt_d <= opt;
    lk_d  <= p_lock_cycle;
    slk_d <= s_lock_cycle;
    // primary request granted and still up
    pg    <= p_req_n ? 1'b0 : (p_frame_start ? 1'b1 : pg);
    ph    <= $fell(p_req_n) ? opt_d[P_HOLD_REQ_BIT] : ph;
    sh    <= $fell(s_req_n) ? opt_d[S_HOLD_REQ_BIT] : sh;
    pl    <= $fell(p_req_n) ? opt_d[LONG_REQ_BIT] & lk_d : pl;
    sl    <= $fell(s_req_n) ? opt_d[LONG_REQ_BIT] & slk_d : sl;
  end
  assign p_fx = (p_fwd_cmd == WRITE_INVALIDATE_CMD && !opt[P_MWI_KEEP_BIT]) ? PLAIN_WRITE_CMD : p_fwd_cmd;
  assign s_fx = (s_fwd_cmd == WRITE_INVALIDATE_CMD && !opt[S_MWI_KEEP_BIT]) ? PLAIN_WRITE_CMD : s_fwd_cmd;
  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  sequence p_grant_s; !p_req_n && p_frame_start; endsequence
  sequence s_grant_s; !s_req_n && s_frame_start; endsequence
  a_rdata_idle: assert property (!reg_read |=> reg_rdata == 32'h0)
    else $error("read data not zero outside a read");
  a_opt_read: assert property (reg_read && reg_addr == OPT_REG_ADDR |=> reg_rdata == {16'h0, $past(opt)})
    else $error("option register read value wrong");
  a_p_exact_hit: assert property (p_retry_valid && p_retry_cmd == p_pend_cmd |=> p_match_valid && p_match_hit)
    else $error("primary exact retry not matched");
  a_s_exact_hit: assert property (s_retry_valid && s_retry_cmd == s_pend_cmd |=> s_match_valid && s_match_hit)
    else $error("secondary exact retry not matched");
  a_match_quiet: assert property (!p_retry_valid && !s_retry_valid |=> !(p_match_valid | s_match_valid))
    else $error("match result without a retry");
  a_p_fwd_cmd: assert property (p_fwd_valid |=> p_out_valid && p_out_cmd == $past(p_fx))
    else $error("primary forwarded command wrong");
  a_s_fwd_cmd: assert property (s_fwd_valid |=> s_out_valid && s_out_cmd == $past(s_fx))
    else $error("secondary forwarded command wrong");
  a_p_req_release: assert property (p_grant_s ##0 !(ph || pl) |=> p_req_n)
    else $error("primary request kept after frame");
  a_s_req_release: assert property (s_grant_s ##0 !(sh || sl) |=> s_req_n)
    else $error("secondary request kept after frame");
  a_p_req_hold: assert property (p_grant_s ##0 ((ph || pl) && p_queue_pending && !p_target_term) |=> !p_req_n)
    else $error("primary request dropped while work pending");
  a_s_req_hold: assert property (s_grant_s ##0 ((sh || sl) && s_queue_pending && !s_target_term) |=> !s_req_n)
    else $error("secondary request dropped while work pending");
  a_lock_long: assert property (pg && !p_req_n && pl && p_lock_cycle && !p_queue_pending && !p_target_term |=> !p_req_n)
    else $error("primary request dropped inside lock");
endmodule
`default_nettype wire

// ---- far_bus_model.sv ----
// far-side bus model: grants the internal master and runs its queued work
`timescale 1ns/1ps
`default_nettype none
module far_bus_model (
  input  wire logic       core_clk,
  input  wire logic       srst,
  input  wire logic       start,
  input  wire logic [1:0] gnt_dly,
  input  wire logic       lock_in,
  input  wire logic       term_in,
  input  wire logic       req_n,
  output logic            queue_pending,
  output logic            frame_start,
  output logic            target_term,
  output logic            xfer_done,
  output logic            lock_cycle,
  output logic            busy
);
  logic [1:0] st;
  logic [2:0] cnt;
  assign busy = st != 2'd0;
  always_ff @(posedge core_clk) begin
    frame_start <= 1'b0;
    target_term <= 1'b0;
    xfer_done   <= 1'b0;
    // lock outlasts the queue by one cycle
    lock_cycle  <= lock_in && (busy || start);
    if (srst) begin
      st            <= 2'd0;
      cnt           <= 3'd0;
      queue_pending <= 1'b0;
    end else if (st == 2'd0) begin
      cnt <= 3'd0;
      if (start) begin
        st            <= 2'd1;
        queue_pending <= 1'b1;
      end
    end else if (st == 2'd1) begin
      if (!req_n) begin
        cnt <= cnt + 3'd1;
        if (cnt[1:0] == gnt_dly) begin
          frame_start <= 1'b1;
          st          <= 2'd2;
          cnt         <= 3'd0;
        end
      end
    end else begin
      cnt         <= cnt + 3'd1;
      target_term <= term_in && cnt == 3'd1;
      if (cnt == 3'd4) begin
        xfer_done     <= 1'b1;
        queue_pending <= 1'b0;
        st            <= 2'd0;
      end
    end
  end
endmodule
`default_nettype wire

// ---- tb_bridge_port_option_control.sv ----
// self-checking bench for the port option control block
`timescale 1ns/1ps
`default_nettype none
module tb_bridge_port_option_control;
  import bridge_port_option_pkg::*;
  logic        core_clk = 1'b0;
  logic        srst = 1'b1;
  logic [7:0]  reg_addr = 8'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic        reg_write = 1'b0, reg_read = 1'b0;
  logic        p_retry_valid = 1'b0, s_retry_valid = 1'b0, p_fwd_valid = 1'b0, s_fwd_valid = 1'b0;
  logic [3:0]  p_retry_cmd = 4'h0, p_pend_cmd = 4'h0, s_retry_cmd = 4'h0, s_pend_cmd = 4'h0;
  logic [3:0]  p_fwd_cmd = 4'h0, s_fwd_cmd = 4'h0, p_out_cmd, s_out_cmd;
  logic        p_match_valid, p_match_hit, s_match_valid, s_match_hit, p_out_valid, s_out_valid;
  logic        p_queue_pending, p_frame_start, p_target_term, p_lock_cycle, p_xfer_done, p_req_n;
  logic        s_queue_pending, s_frame_start, s_target_term, s_lock_cycle, s_xfer_done, s_req_n;
  logic        p_go = 1'b0, s_go = 1'b0, p_lk = 1'b0, s_lk = 1'b0, p_tm = 1'b0, s_tm = 1'b0, pb, sb;
  logic [1:0]  p_gd = 2'd0, s_gd = 2'd0;
  logic [15:0] opt = 16'h0c6a;
  logic [31:0] lf = 32'head441ea;
  logic [3:0]  cmds [8] = '{4'h6, 4'h7, 4'hc, 4'he, 4'hf, 4'h0, 4'h3, 4'hb};
  logic [31:0] rd_q[$];
  logic        pm_q[$], sm_q[$], pr_q[$], sr_q[$];
  logic [3:0]  po_q[$], so_q[$];
  logic        rd_d = 1'b0, pf_d = 1'b0, sf_d = 1'b0;
  int          error_cnt = 0, cmp_count = 0;
  always #50 core_clk = ~core_clk;
  bridge_port_option_control dut (.*);
  far_bus_model pm (.core_clk(core_clk), .srst(srst), .start(p_go), .gnt_dly(p_gd), .lock_in(p_lk),
    .term_in(p_tm), .req_n(p_req_n), .queue_pending(p_queue_pending), .frame_start(p_frame_start),
    .target_term(p_target_term), .xfer_done(p_xfer_done), .lock_cycle(p_lock_cycle), .busy(pb));
  far_bus_model sm (.core_clk(core_clk), .srst(srst), .start(s_go), .gnt_dly(s_gd), .lock_in(s_lk),
    .term_in(s_tm), .req_n(s_req_n), .queue_pending(s_queue_pending), .frame_start(s_frame_start),
    .target_term(s_target_term), .xfer_done(s_xfer_done), .lock_cycle(s_lock_cycle), .busy(sb));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic hit(input logic [3:0] r, input logic [3:0] p, input logic ra, input logic wa,
                               input logic la);
    logic rl;
    logic pl;
    rl = r == READ_LINE_CMD || r == READ_MULTIPLE_CMD;
    pl = p == READ_LINE_CMD || p == READ_MULTIPLE_CMD;
    return r == p || (ra && rl && p == PLAIN_READ_CMD) || (la && rl && pl) ||
           (wa && r == WRITE_INVALIDATE_CMD && p == PLAIN_WRITE_CMD);
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    if (a == OPT_REG_ADDR) opt = d[15:0] & OPT_WRITE_MASK;
    @(posedge core_clk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    rd_q.push_back(e);
    @(posedge core_clk);
    reg_read <= 1'b0;
  endtask
  // one cycle of retries and forwards on both ports, valids random
  task automatic ops();
    logic [3:0] c [6];
    lf = lfsr(lf);
    for (int j = 0; j < 6; j++) c[j] = cmds[lf[3*j+:3]];
    @(posedge core_clk);
    {p_retry_valid, s_retry_valid, p_fwd_valid, s_fwd_valid} <= lf[21:18];
    {p_retry_cmd, p_pend_cmd, s_retry_cmd, s_pend_cmd, p_fwd_cmd, s_fwd_cmd} <= {c[0], c[1], c[2], c[3], c[4], c[5]};
    if (lf[21]) pm_q.push_back(hit(c[0], c[1], opt[P_READ_ALIAS_BIT], opt[P_WRITE_ALIAS_BIT], opt[P_LM_ALIAS_BIT]));
    if (lf[20]) sm_q.push_back(hit(c[2], c[3], opt[S_READ_ALIAS_BIT], opt[S_WRITE_ALIAS_BIT], opt[S_LM_ALIAS_BIT]));
    if (lf[19]) po_q.push_back((c[4] == WRITE_INVALIDATE_CMD && !opt[P_MWI_KEEP_BIT]) ? PLAIN_WRITE_CMD : c[4]);
    if (lf[18]) so_q.push_back((c[5] == WRITE_INVALIDATE_CMD && !opt[S_MWI_KEEP_BIT]) ? PLAIN_WRITE_CMD : c[5]);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  always @(negedge core_clk) begin
    if (rd_d) chk("rdata", reg_rdata, rd_q.pop_front());
    if (p_match_valid === 1'b1) chk("p_hit", 32'(p_match_hit), 32'(pm_q.pop_front()));
    if (s_match_valid === 1'b1) chk("s_hit", 32'(s_match_hit), 32'(sm_q.pop_front()));
    if (p_out_valid === 1'b1) chk("p_cmd", 32'(p_out_cmd), 32'(po_q.pop_front()));
    if (s_out_valid === 1'b1) chk("s_cmd", 32'(s_out_cmd), 32'(so_q.pop_front()));
    if (pf_d) chk("p_req", 32'(p_req_n), 32'(pr_q.pop_front()));
    if (sf_d) chk("s_req", 32'(s_req_n), 32'(sr_q.pop_front()));
    rd_d = reg_read;
    pf_d = p_frame_start;
    sf_d = s_frame_start;
  end
  initial begin
    #2_000_000;
    error_cnt++;
    end_sim();
  end
  initial begin
    logic [15:0] v;
    repeat (4) @(posedge core_clk);
    srst <= 1'b0;
    rd(OPT_REG_ADDR, 32'h0000_0c6a);
    rd(STATUS_REG_ADDR, 32'h0);
    rd(8'h40, 32'h0);
    wr(OPT_REG_ADDR, 32'hffff_ffff);
    rd(OPT_REG_ADDR, 32'h0000_0ffe);
    wr(8'h40, 32'h0);
    rd(OPT_REG_ADDR, 32'h0000_0ffe);
    for (int i = 0; i < 8; i++) begin
      lf = lfsr(lf);
      v = i[0] ? ~v : lf[15:0];
      wr(OPT_REG_ADDR, {16'h0, v});
      repeat (40) ops();
      @(posedge core_clk);
      {p_retry_valid, s_retry_valid, p_fwd_valid, s_fwd_valid} <= 4'h0;
    end
    for (logic [3:0] k = 0; k < 8; k++) begin
      lf = lfsr(lf);
      wr(OPT_REG_ADDR, {16'h0, 4'h0, k[2:0], lf[8:0]});
      pr_q.push_back(!(opt[P_HOLD_REQ_BIT] | (opt[LONG_REQ_BIT] & (lf[13] | (k == 7)))));
      sr_q.push_back(!(opt[S_HOLD_REQ_BIT] | (opt[LONG_REQ_BIT] & lf[14])));
      @(posedge core_clk);
      {p_gd, s_gd, p_lk, s_lk} <= {lf[12:9], lf[13] | (k == 7), lf[14]};
      {p_tm, s_tm} <= {lf[15] & (k != 7), lf[16]};
      {p_go, s_go} <= 2'b11;
      @(posedge core_clk);
      {p_go, s_go} <= 2'b00;
      repeat (2) @(negedge core_clk);
      for (int n = 0; n < 60 && (pb || sb); n++) @(negedge core_clk);
      chk("busy", 32'(pb | sb), 32'h0);
      repeat (3) @(negedge core_clk);
    end
    rd(STATUS_REG_ADDR, 32'h0);
    repeat (3) @(negedge core_clk);
    chk("left", 32'(rd_q.size() + pm_q.size() + sm_q.size() + po_q.size() + so_q.size() + pr_q.size() + sr_q.size()),
        32'h0);
    end_sim();
  end
endmodule
bind bridge_port_option_control bridge_port_option_monitor mon (.*);
`default_nettype wire
